// File: verilog/cwgsdb_top.sv
// Complementary waveform generator: steering, full and half bridge,
// push-pull, with two double-buffered 6-bit dead-band counters.
// Assumes settings are quasi-static ports; sources are asynchronous.
`timescale 1ns/1ps
`default_nettype none

module cwgsdb_top #(
    parameter int DB_W = cwgsdb_pkg::DB_W
) (
    // Clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_reset_n,
    // Global control
    input  wire logic                            i_enable,
    input  wire logic [2:0]                      i_mode,
    input  wire logic [cwgsdb_pkg::SRC_W-1:0]    i_source_select,
    input  wire logic [cwgsdb_pkg::NUM_SRC-1:0]  i_sources,
    // Dead-band clock
    input  wire logic                            i_clock_select,
    input  wire logic                            i_internal_fast_osc,
    input  wire logic                            i_sleep,
    // Output shaping
    input  wire logic [cwgsdb_pkg::NUM_OUT-1:0]  i_output_polarity,
    input  wire logic [cwgsdb_pkg::NUM_OUT-1:0]  i_steer_select,
    input  wire logic [cwgsdb_pkg::NUM_OUT-1:0]  i_steer_level,
    input  wire logic                            i_shutdown,
    input  wire logic [cwgsdb_pkg::NUM_OUT-1:0]  i_override_level,
    // Dead-band counts
    input  wire logic [DB_W-1:0]                 i_rise_deadband_count,
    input  wire logic [DB_W-1:0]                 i_fall_deadband_count,
    input  wire logic                            i_count_write,
    input  wire logic                            i_load_request_set,
    // Outputs
    output logic                                 o_output_a,
    output logic                                 o_output_b,
    output logic                                 o_output_c,
    output logic                                 o_output_d,
    output logic                                 o_load_request,
    output logic                                 o_direction_reverse
);
    localparam int NO = cwgsdb_pkg::NUM_OUT;

    logic [cwgsdb_pkg::NUM_SRC-1:0] src_sync;
    logic                           osc_sync;
    logic                           osc_d_ff;
    logic                           in_ff;
    logic                           in_d_ff;
    logic                           rise_edge;
    logic                           fall_edge;
    logic                           db_tick;
    logic                           steering;
    logic                           half;
    logic                           push;
    logic                           fb;
    logic                           fb_change;
    logic                           to_rev;
    logic [NO-1:0]                  str_ff;
    logic [DB_W-1:0]                rise_buf_ff;
    logic [DB_W-1:0]                fall_buf_ff;
    logic                           load_req_ff;
    logic                           armed_ff;
    logic                           rise_start;
    logic                           rise_abort;
    logic                           rise_busy;
    logic                           rise_done;
    logic                           fall_start;
    logic                           fall_abort;
    logic                           fall_busy;
    logic                           fall_done;
    logic                           a_on_ff;
    logic                           b_on_ff;
    logic                           pp_a_ff;
    logic                           pp_cur;
    logic [NO-1:0]                  act;
    logic [NO-1:0]                  out_ff;
    cwgsdb_pkg::cwgsdb_dir_e        dir_ff;
    cwgsdb_pkg::cwgsdb_dir_e        mode_dir;

    // ========================================================
    // Input capture
    // Sources and oscillator are asynchronous pins
    cwgsdb_sync #(
        .WIDTH (cwgsdb_pkg::NUM_SRC)
    ) u_src_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   (i_sources),
        .o_sync    (src_sync)
    );

    cwgsdb_sync #(
        .WIDTH (1)
    ) u_osc_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   (i_internal_fast_osc),
        .o_sync    (osc_sync)
    );

    // Selected input and its previous value for edge detection
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            in_ff    <= 1'b0;
            in_d_ff  <= 1'b0;
            osc_d_ff <= 1'b0;
        end else begin
            in_ff    <= src_sync[i_source_select];
            in_d_ff  <= in_ff;
            osc_d_ff <= osc_sync;
        end
    end

    assign rise_edge = in_ff && !in_d_ff;
    assign fall_edge = !in_ff && in_d_ff;

    // Dead-band tick: oscillator edges, or every system cycle awake
    assign db_tick = i_clock_select ? (osc_sync && !osc_d_ff)
                                    : !i_sleep;

    // ========================================================
    // Mode decode
    assign steering = (i_mode == cwgsdb_pkg::MODE_ASYNC_STEER) ||
                      (i_mode == cwgsdb_pkg::MODE_SYNC_STEER);
    assign half     = (i_mode == cwgsdb_pkg::MODE_HALF);
    assign push     = (i_mode == cwgsdb_pkg::MODE_PUSH);
    assign fb       = (i_mode[2:1] == cwgsdb_pkg::MODE_FB_HI);
    assign mode_dir = (i_mode == cwgsdb_pkg::MODE_REV)
                      ? cwgsdb_pkg::CWGSDB_DIR_REV
                      : cwgsdb_pkg::CWGSDB_DIR_FWD;
    assign fb_change = i_enable && fb && rise_edge && (mode_dir != dir_ff);
    assign to_rev    = (mode_dir == cwgsdb_pkg::CWGSDB_DIR_REV);

    // ========================================================
    // Steering selection
    // Async takes the new selection at once, sync at input rise
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            str_ff <= cwgsdb_pkg::OUT_RESET;
        end else if (i_mode == cwgsdb_pkg::MODE_ASYNC_STEER || !i_enable) begin
            str_ff <= i_steer_select;
        end else if (rise_edge) begin
            str_ff <= i_steer_select;
        end
    end

    // ========================================================
    // Full-bridge direction
    // Direction follows the mode every cycle while disabled, else only at an input rising edge
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dir_ff <= cwgsdb_pkg::CWGSDB_DIR_FWD;
        end else begin
            case (1'b1)
                !i_enable: dir_ff <= mode_dir;
                fb_change: dir_ff <= mode_dir;
                default:   dir_ff <= dir_ff;
            endcase
        end
    end

    assign o_direction_reverse = (dir_ff == cwgsdb_pkg::CWGSDB_DIR_REV);

    // ========================================================
    // Dead-band count buffers
    // Disabled: write loads; enabled: rise after fall after request
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rise_buf_ff <= cwgsdb_pkg::DB_RESET;
            fall_buf_ff <= cwgsdb_pkg::DB_RESET;
        end else if (!i_enable && i_count_write) begin
            rise_buf_ff <= i_rise_deadband_count;
            fall_buf_ff <= i_fall_deadband_count;
        end else if (i_enable && armed_ff && rise_edge) begin
            rise_buf_ff <= i_rise_deadband_count;
            fall_buf_ff <= i_fall_deadband_count;
        end
    end

    // Load request: a set in the clearing cycle wins
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            load_req_ff <= 1'b0;
        end else if (i_load_request_set) begin
            load_req_ff <= 1'b1;
        end else if (i_enable && armed_ff && rise_edge) begin
            load_req_ff <= 1'b0;
        end
    end

    // Arm on the first falling edge after the request
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            armed_ff <= 1'b0;
        end else if (!i_enable || !load_req_ff) begin
            armed_ff <= 1'b0;
        end else if (armed_ff && rise_edge) begin
            armed_ff <= 1'b0;
        end else if (fall_edge) begin
            armed_ff <= 1'b1;
        end
    end

    assign o_load_request = load_req_ff;

    // ========================================================
    // Dead-band counters
    // Rise: half-bridge rise, or full-bridge change to reverse
    assign rise_start = i_enable &&
                        ((half && rise_edge) || (fb_change && to_rev));
    assign rise_abort = !i_enable || (half && fall_edge);
    // Fall: half-bridge fall, or full-bridge change to forward
    assign fall_start = i_enable &&
                        ((half && fall_edge) || (fb_change && !to_rev));
    assign fall_abort = !i_enable || (half && rise_edge);

    cwgsdb_db_timer #(
        .W (DB_W)
    ) u_rise_timer (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_start   (rise_start),
        .i_abort   (rise_abort),
        .i_tick    (db_tick),
        .i_count   (rise_buf_ff),
        .o_busy    (rise_busy),
        .o_done    (rise_done)
    );

    cwgsdb_db_timer #(
        .W (DB_W)
    ) u_fall_timer (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_start   (fall_start),
        .i_abort   (fall_abort),
        .i_tick    (db_tick),
        .i_count   (fall_buf_ff),
        .o_busy    (fall_busy),
        .o_done    (fall_done)
    );

    // Half-bridge turn-on latches, dropped when the input reverses
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            a_on_ff <= 1'b0;
            b_on_ff <= 1'b0;
        end else begin
            a_on_ff <= half && in_ff && (a_on_ff || rise_done);
            b_on_ff <= half && !in_ff && (b_on_ff || fall_done);
        end
    end

    // Push-pull sequencer; first pulse goes to output a
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pp_a_ff <= 1'b0;
        end else if (!i_enable || i_shutdown) begin
            pp_a_ff <= 1'b0;
        end else if (push && rise_edge) begin
            pp_a_ff <= !pp_a_ff;
        end
    end

    assign pp_cur = rise_edge ? !pp_a_ff : pp_a_ff;

    // ========================================================
    // Active-level waveforms per mode, before polarity
    always_comb begin
        act = '0;
        case (1'b1)
            steering: begin
                act = {NO{in_ff}};
            end
            fb: begin
                if (dir_ff == cwgsdb_pkg::CWGSDB_DIR_FWD) begin
                    act[cwgsdb_pkg::OUT_A] = 1'b1;
                    act[cwgsdb_pkg::OUT_D] = in_ff && !fall_busy &&
                                             !fall_start;
                end else begin
                    act[cwgsdb_pkg::OUT_C] = 1'b1;
                    act[cwgsdb_pkg::OUT_B] = in_ff && !rise_busy &&
                                             !rise_start;
                end
            end
            half: begin
                act[cwgsdb_pkg::OUT_A] = in_ff && (a_on_ff || rise_done);
                act[cwgsdb_pkg::OUT_B] = !in_ff && (b_on_ff || fall_done);
                act[cwgsdb_pkg::OUT_C] = act[cwgsdb_pkg::OUT_A];
                act[cwgsdb_pkg::OUT_D] = act[cwgsdb_pkg::OUT_B];
            end
            push: begin
                act[cwgsdb_pkg::OUT_A] = in_ff && pp_cur;
                act[cwgsdb_pkg::OUT_B] = in_ff && !pp_cur;
                act[cwgsdb_pkg::OUT_C] = act[cwgsdb_pkg::OUT_A];
                act[cwgsdb_pkg::OUT_D] = act[cwgsdb_pkg::OUT_B];
            end
            default: begin
                act = '0;
            end
        endcase
    end

    // ========================================================
    // Output stage: override, fixed level or polarity-shaped wave
    for (genvar gi = 0; gi < NO; gi++) begin : g_out
        always_ff @(posedge i_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                out_ff[gi] <= 1'b0;
            end else if (steering && !str_ff[gi] && i_enable) begin
                out_ff[gi] <= i_steer_level[gi];
            end else if (!i_enable || i_shutdown) begin
                out_ff[gi] <= i_override_level[gi];
            end else begin
                out_ff[gi] <= i_output_polarity[gi] ? act[gi]
                                                    : !act[gi];
            end
        end
    end

    assign o_output_a = out_ff[cwgsdb_pkg::OUT_A];
    assign o_output_b = out_ff[cwgsdb_pkg::OUT_B];
    assign o_output_c = out_ff[cwgsdb_pkg::OUT_C];
    assign o_output_d = out_ff[cwgsdb_pkg::OUT_D];

    // ========================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_fb_to_rev;
        fb_change && to_rev && rise_buf_ff != '0;
    endsequence

    a_steer_fixed_lvl: assert property (
        i_enable && steering && !str_ff[cwgsdb_pkg::OUT_A]
        |=> o_output_a == $past(i_steer_level[cwgsdb_pkg::OUT_A]))
        else $error("fixed steer level not shown on output a");

    a_async_steer_now: assert property (
        i_mode == cwgsdb_pkg::MODE_ASYNC_STEER
        |=> str_ff == $past(i_steer_select))
        else $error("async steering did not take effect");

    a_sync_steer_hold: assert property (
        i_enable && i_mode == cwgsdb_pkg::MODE_SYNC_STEER && !rise_edge
        |=> $stable(str_ff))
        else $error("sync steering changed off a rising edge");

    a_steer_shutdown: assert property (
        i_enable && steering && i_shutdown && str_ff[cwgsdb_pkg::OUT_B]
        |=> o_output_b == $past(i_override_level[cwgsdb_pkg::OUT_B]))
        else $error("shutdown did not override steered output b");

    a_fb_static_pair: assert property (
        i_enable && fb && !i_shutdown &&
        dir_ff == cwgsdb_pkg::CWGSDB_DIR_FWD
        |=> o_output_a == $past(i_output_polarity[cwgsdb_pkg::OUT_A]) &&
            o_output_c == !$past(i_output_polarity[cwgsdb_pkg::OUT_C]))
        else $error("forward bridge static outputs wrong");

    a_fb_rev_gap: assert property (
        s_fb_to_rev ##1 (!i_shutdown && i_enable && fb)
        |=> o_output_b == !$past(i_output_polarity[cwgsdb_pkg::OUT_B]))
        else $error("output b modulated inside reverse dead band");

    a_disabled_load: assert property (
        !i_enable && i_count_write
        |=> rise_buf_ff == $past(i_rise_deadband_count) &&
            fall_buf_ff == $past(i_fall_deadband_count))
        else $error("disabled write did not load count buffers");

    a_ld_self_clear: assert property (
        i_enable && armed_ff && rise_edge && !i_load_request_set
        |=> !o_load_request)
        else $error("load request not cleared after transfer");

    a_half_zero_db: assert property (
        i_enable && half && rise_edge && rise_buf_ff == '0 && !i_shutdown
        |=> o_output_a == $past(i_output_polarity[cwgsdb_pkg::OUT_A]))
        else $error("zero rise count delayed output a");
endmodule : cwgsdb_top

`default_nettype wire

// File: verilog/cwgsdb_pkg.sv
// Package for the complementary waveform steering and dead-band block.
// Assumes a single 100 MHz system clock; no bus, all settings are ports.
`default_nettype none

package cwgsdb_pkg;
    // ========================================================
    // Sizes
    localparam int DB_W    = 6;              // Dead-band count width
    localparam int SRC_W   = 3;              // Source select width
    localparam int NUM_SRC = 8;              // Selectable input sources
    localparam int NUM_OUT = 4;              // Outputs a..d

    // ========================================================
    // Mode codes
    localparam logic [2:0] MODE_ASYNC_STEER = 3'h0;
    localparam logic [2:0] MODE_SYNC_STEER  = 3'h1;
    localparam logic [2:0] MODE_FWD         = 3'h2;
    localparam logic [2:0] MODE_REV         = 3'h3;
    localparam logic [2:0] MODE_HALF        = 3'h4;
    localparam logic [2:0] MODE_PUSH        = 3'h5;
    localparam logic [1:0] MODE_FB_HI       = 2'h1; // Mode bits 2:1

    // ========================================================
    // Output indices and reset values
    localparam int OUT_A = 0;
    localparam int OUT_B = 1;
    localparam int OUT_C = 2;
    localparam int OUT_D = 3;
    localparam logic [NUM_OUT-1:0] OUT_RESET = 4'h0;
    localparam logic [DB_W-1:0]    DB_RESET  = 6'h00;

    // Full-bridge direction
    typedef enum logic [1:0] {
        CWGSDB_DIR_FWD = 2'b01,
        CWGSDB_DIR_REV = 2'b10
    } cwgsdb_dir_e;
endpackage : cwgsdb_pkg

`default_nettype wire

// File: verilog/cwgsdb_sync.sv
// Three-flop synchroniser for asynchronous inputs.
// A change is accepted once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none

module cwgsdb_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] val_ff;

    // ========================================================
    // Shift chain; stage one feeds stage two only
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= i_async;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Accept bits where stages two and three agree
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            val_ff <= '0;
        end else begin
            val_ff <= (s2_ff & s3_ff) | (val_ff & (s2_ff | s3_ff));
        end
    end

    assign o_sync = val_ff;
endmodule : cwgsdb_sync

`default_nettype wire

// File: verilog/cwgsdb_db_timer.sv
// One dead-band counter: counts selected-clock ticks from zero up to
// the count latched at start. Assumes ticks are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module cwgsdb_db_timer #(
    parameter int W = 6
) (
    // Clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    // Control
    input  wire logic         i_start,
    input  wire logic         i_abort,
    input  wire logic         i_tick,
    input  wire logic [W-1:0] i_count,
    // Status
    output logic              o_busy,
    output logic              o_done
);
    logic [W-1:0] cnt_ff;
    logic [W-1:0] lim_ff;
    logic         busy_ff;
    logic [W-1:0] nxt_cnt;

    assign nxt_cnt = cnt_ff + W'(1);

    // Count ticks while busy; abort drops the interval
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            busy_ff <= 1'b0;
            cnt_ff  <= '0;
            lim_ff  <= '0;
        end else if (i_abort) begin
            busy_ff <= 1'b0;
        end else if (i_start) begin
            busy_ff <= (i_count != '0);
            cnt_ff  <= '0;
            lim_ff  <= i_count;
        end else if (busy_ff && i_tick) begin
            cnt_ff <= nxt_cnt;
            if (nxt_cnt == lim_ff) begin
                busy_ff <= 1'b0;
            end
        end
    end

    // Zero count ends at once; otherwise on the last tick
    assign o_done = !i_abort &&
                    ((i_start && i_count == '0) ||
                     (!i_start && busy_ff && i_tick && nxt_cnt == lim_ff));
    assign o_busy = busy_ff;
endmodule : cwgsdb_db_timer

`default_nettype wire

// File: test/cwgsdb_gate_model.sv
// Gate driver model for the two bridge legs behind outputs a..d.
// Assumes active-high gates; legs are a/b and c/d.
`timescale 1ns/1ps
`default_nettype none

module cwgsdb_gate_model (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // Gates
    input  wire logic i_gate_a,
    input  wire logic i_gate_b,
    input  wire logic i_gate_c,
    input  wire logic i_gate_d,
    input  wire logic i_watch,
    // Sticky flag: both switches of one leg were on
    output logic      o_overlap
);
    // ========================================================
    // Shoot-through watch, only while i_watch is high (bench: any mode above sync steering)
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) o_overlap <= 1'b0;
        else if (i_watch && ((i_gate_a && i_gate_b) || (i_gate_c && i_gate_d)))
            o_overlap <= 1'b1;
    end
endmodule : cwgsdb_gate_model

`default_nettype wire

// File: test/cwgsdb_top_test.sv
// Self-checking bench for the steering and dead-band waveform block.
// Assumes a 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none

module cwgsdb_top_test;
    logic       clk = 1'b0, rst_n = 1'b0, en = 1'b0, sd = 1'b0;
    logic       cks = 1'b0, osc = 1'b0, slp = 1'b0, wr = 1'b0, lds = 1'b0;
    logic [2:0] mode = 3'h0, ssel = 3'h0;
    logic [7:0] src = 8'h00;
    logic [3:0] pol = 4'hF, str = 4'h0, lvl = 4'h0, ovr = 4'hA;
    logic [5:0] dbr = 6'h14, dbf = 6'h0A;
    logic       a, b, c, d, ldreq, rev, ovl;
    int         failures = 0, samples_checked = 0;
    wire  [3:0] q = {d, c, b, a};

    // ========================================================
    // Clock, device and gate model
    always #5 clk = ~clk;
    // Slow stand-in for the fast oscillator: one rising edge per 8 cycles
    always #40 osc = ~osc;
    cwgsdb_top dut (.i_clk(clk), .i_reset_n(rst_n), .i_enable(en),
        .i_mode(mode), .i_source_select(ssel), .i_sources(src),
        .i_clock_select(cks), .i_internal_fast_osc(osc), .i_sleep(slp),
        .i_output_polarity(pol), .i_steer_select(str), .i_steer_level(lvl),
        .i_shutdown(sd), .i_override_level(ovr),
        .i_rise_deadband_count(dbr), .i_fall_deadband_count(dbf),
        .i_count_write(wr), .i_load_request_set(lds), .o_output_a(a),
        .o_output_b(b), .o_output_c(c), .o_output_d(d),
        .o_load_request(ldreq), .o_direction_reverse(rev));
    cwgsdb_gate_model partner (.i_clk(clk), .i_reset_n(rst_n), .i_gate_a(a),
        .i_gate_b(b), .i_gate_c(c), .i_gate_d(d), .i_watch(mode > 3'h1),
        .o_overlap(ovl));

    // ========================================================
    // Shared helpers
    task automatic check(input string what, input logic [3:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic put(input logic v);
        src = v ? (8'h01 << ssel) : 8'h00;
    endtask : put
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // ========================================================
    // Scenarios
    task automatic t_steer();
        cyc(3);
        check("override", q, 4'hA);
        wr = 1'b1; // Counts 20 and 10 load while disabled
        cyc(1);
        wr = 1'b0;
        pol = 4'h5; str = 4'h3; lvl = 4'h8; ovr = 4'h0; en = 1'b1;
        for (int s = 0; s < 8; s++) begin
            ssel = s[2:0];
            put(1'b1); cyc(8);
            check("steer hi", q, 4'h9);
            put(1'b0); cyc(8);
            check("steer lo", q, 4'hA);
        end
        sd = 1'b1; cyc(3);
        check("shutdown", q, 4'h8);
        sd = 1'b0; lvl = 4'h4; cyc(2);
        check("level", q, 4'h6);
        str = 4'h1; cyc(3);
        check("async", q, 4'h4);
        $display("steering done");
    endtask : t_steer

    task automatic t_sync();
        en = 1'b0; mode = 3'h1; str = 4'h3; cyc(2);
        en = 1'b1; cyc(2);
        str = 4'h2; cyc(6);
        check("sync hold", q, 4'h6);
        put(1'b1); cyc(8);
        check("sync new", q, 4'h4);
        $display("sync steering done");
    endtask : t_sync

    task automatic t_bridge();
        en = 1'b0; pol = 4'hF; mode = 3'h2; put(1'b0); cyc(2);
        en = 1'b1; cyc(8);
        check("fwd lo", q, 4'h1);
        put(1'b1); cyc(8);
        check("fwd hi", q, 4'h9);
        put(1'b0); cyc(8);
        mode = 3'h3; cyc(8);
        check("no edge", q, 4'h1);
        put(1'b1); cyc(8);
        check("to rev", q, 4'h4);
        check("dir", {3'h0, rev}, 4'h1);
        cyc(20);
        check("rev on", q, 4'h6);
        put(1'b0); cyc(8);
        mode = 3'h2; put(1'b1); cyc(8);
        check("to fwd", q, 4'h1);
        cyc(12);
        check("fwd on", q, 4'h9);
        $display("full bridge done");
    endtask : t_bridge

    task automatic t_half();
        en = 1'b0; mode = 3'h4; put(1'b0); cyc(2);
        en = 1'b1; cyc(20);
        check("half lo", q, 4'hA);
        put(1'b1); cyc(10);
        check("rise gap", q, 4'h0);
        cyc(20);
        check("half hi", q, 4'h5);
        put(1'b0); cyc(8);
        check("fall gap", q, 4'h0);
        cyc(12);
        check("half lo2", q, 4'hA);
        dbr = 6'h00; lds = 1'b1; cyc(1);
        lds = 1'b0; put(1'b1); cyc(30);
        check("ld held", {3'h0, ldreq}, 4'h1);
        put(1'b0); cyc(20);
        put(1'b1); cyc(8);
        check("ld clear", {3'h0, ldreq}, 4'h0);
        put(1'b0); cyc(20);
        put(1'b1); cyc(8);
        check("new count", q, 4'h5);
        check("overlap", {3'h0, ovl}, 4'h0);
        // Oscillator ticks keep the fall count running through sleep
        cks = 1'b1; slp = 1'b1; put(1'b0); cyc(40);
        check("osc gap", q, 4'h0);
        cyc(60);
        check("osc on", q, 4'hA);
        $display("half bridge done");
    endtask : t_half

    task automatic t_push();
        en = 1'b0; mode = 3'h5; pol = 4'h7; cyc(2);
        en = 1'b1; put(1'b1); cyc(8);
        check("push a", q, 4'hD);
        put(1'b0); cyc(8);
        check("push off", q, 4'h8);
        put(1'b1); cyc(8);
        check("push b", q, 4'h2);
        $display("push-pull done");
    endtask : t_push

    // ========================================================
    // Main sequence and watchdog
    initial begin
        cyc(6);
        rst_n = 1'b1;
        t_steer();
        t_sync();
        t_bridge();
        t_half();
        t_push();
        summarize();
    end
    initial begin
        #50000;
        failures++;
        summarize();
    end
endmodule : cwgsdb_top_test

`default_nettype wire
